/* hdl/dual_port_counter_pkg.sv */
// Shared constants and types for the dual-port loadable up counter
`default_nettype none

package dual_port_counter_pkg;

  // Counter width as built
  localparam int COUNT_WIDTH = 4;

  // Counter value after reset or synchronous clear
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 4'h0;

  // Increment step while counting
  localparam logic [COUNT_WIDTH-1:0] COUNT_STEP = 4'h1;

  // Output enables after reset: all outputs floating
  localparam logic OE_RESET = 1'b0;

  // Operating modes decoded from the two mode-select bits
  typedef enum logic [1:0] {
    MODE_LOAD_A,
    MODE_LOAD_B,
    MODE_RUN_NORMAL,
    MODE_RUN_SWAPPED
  } mode_e;

endpackage : dual_port_counter_pkg

`default_nettype wire

/* hdl/lane_order.sv */
// Bit-order selector: passes a word straight or bit-reversed
`timescale 1ns/1ps
`default_nettype none

module lane_order #(
  parameter int WIDTH = 4
) (
  // Word in
  input wire logic [WIDTH-1:0] i_word,
  input wire logic i_reverse,
  // Word out
  output logic [WIDTH-1:0] o_word
);

  if (WIDTH < 1) begin : g_width_check
    $error("lane_order: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] reversed;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      reversed[i] = i_word[WIDTH-1-i];
    end
    o_word = i_reverse ? reversed : i_word;
  end

endmodule : lane_order

`default_nettype wire

/* hdl/dual_port_up_counter.sv */
// Dual-port loadable up counter with three-state count bus and bidirectional port
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Holds a 4-bit count, loadable from port A or port B, and counts up.
// - Select 00 loads A, 01 loads B, 10 run normal, 11 run swapped.
// - In run modes, carry high increments by one; carry low holds the count.
// - Counter bits change only on the rising clock edge, or at once when the reset input goes low.
// - Synchronous clear at a clock edge zeroes the count, overriding every mode.
// - Count bus driven from the edge after output enable goes low, floating from the edge after it goes high.
// - Port B driven from the clock edge after a run mode is selected, released the edge after a load mode is selected.
// - Each conditionally enabled output floats from the clock edge after its enable condition goes false.
// - Port B carries the count normal, or bit-reversed when select low is set.
module dual_port_up_counter #(
  parameter int WIDTH = dual_port_counter_pkg::COUNT_WIDTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Control
  input wire logic i_counter_clear,
  input wire logic i_mode_select_low,
  input wire logic i_mode_select_high,
  input wire logic i_carry_input,
  input wire logic i_output_enable_n,
  // Dedicated load port
  input wire logic [WIDTH-1:0] i_port_a_inputs,
  // Bidirectional port
  input wire logic [WIDTH-1:0] i_port_b_lines,
  output logic [WIDTH-1:0] o_port_b_lines,
  output logic o_port_b_lines_oe,
  // Three-state count bus
  output logic [WIDTH-1:0] o_count,
  output logic o_count_oe
);

  import dual_port_counter_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  // Reset and step constants are sized to the built width
  if (WIDTH != COUNT_WIDTH) begin : g_width_check
    $error("dual_port_up_counter: WIDTH must equal COUNT_WIDTH");
  end

  // Run mode must move the count, so a zero step is refused
  if (COUNT_STEP == '0) begin : g_step_check
    $error("dual_port_up_counter: COUNT_STEP must not be zero");
  end

  // Synchronous clear must land on zero
  if (COUNT_RESET != '0) begin : g_clear_check
    $error("dual_port_up_counter: COUNT_RESET must be zero");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode

  mode_e mode;

  always_comb begin
    unique case ({i_mode_select_high, i_mode_select_low})
      2'h0: begin
        mode = MODE_LOAD_A;
      end
      2'h1: begin
        mode = MODE_LOAD_B;
      end
      2'h2: begin
        mode = MODE_RUN_NORMAL;
      end
      2'h3: begin
        mode = MODE_RUN_SWAPPED;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operation flags

  logic run_mode;
  logic swap_order;
  logic count_step_due;

  always_comb begin
    run_mode = 1'b0;
    swap_order = 1'b0;
    unique case (mode)
      MODE_LOAD_A: begin
        run_mode = 1'b0;
      end
      MODE_LOAD_B: begin
        run_mode = 1'b0;
      end
      MODE_RUN_NORMAL: begin
        run_mode = 1'b1;
      end
      MODE_RUN_SWAPPED: begin
        run_mode = 1'b1;
        swap_order = 1'b1;
      end
    endcase
    // Carry is looked at only in run modes
    count_step_due = run_mode && i_carry_input;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter state

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  logic [WIDTH-1:0] load_value;
  logic [WIDTH-1:0] count_plus_step;

  always_comb begin
    // Port B feeds the counter in load-B mode, even on the first edge while the device still drives it
    if (mode == MODE_LOAD_B) begin
      load_value = i_port_b_lines;
    end else begin
      load_value = i_port_a_inputs;
    end
    // Wraps from all ones to zero
    count_plus_step = count + COUNT_STEP;
  end

  always_comb begin
    next_count = count;
    if (i_counter_clear) begin
      // Clear beats load, hold and count
      next_count = COUNT_RESET;
    end else begin
      unique case (mode)
        MODE_LOAD_A, MODE_LOAD_B: begin
          // Carry is ignored while loading
          next_count = load_value;
        end
        MODE_RUN_NORMAL, MODE_RUN_SWAPPED: begin
          if (count_step_due) begin
            next_count = count_plus_step;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port B drive

  // Ordered from the next count so port data tracks the counter edge for edge
  logic [WIDTH-1:0] ordered_next;
  logic [WIDTH-1:0] next_port_b_lines;
  logic next_port_b_lines_oe;

  lane_order #(
    .WIDTH(WIDTH)
  ) u_lane_order (
    .i_word(next_count),
    .i_reverse(swap_order),
    .o_word(ordered_next)
  );

  always_comb begin
    // Enable follows the select one edge later; owner must already be off
    next_port_b_lines_oe = run_mode;
    if (run_mode) begin
      next_port_b_lines = ordered_next;
    end else begin
      // Undriven lines read zero so a released port shows no stale count
      next_port_b_lines = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_port_b_lines <= COUNT_RESET;
      o_port_b_lines_oe <= OE_RESET;
    end else begin
      o_port_b_lines <= next_port_b_lines;
      o_port_b_lines_oe <= next_port_b_lines_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Count bus drive

  logic next_count_oe;

  always_comb begin
    // Registered so the bus pins come straight from flip-flops
    if (i_output_enable_n) begin
      // Bus floats while the enable pin is high
      next_count_oe = 1'b0;
    end else begin
      next_count_oe = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_count_oe <= OE_RESET;
    end else begin
      o_count_oe <= next_count_oe;
    end
  end

  always_comb begin
    o_count = count;
  end

endmodule : dual_port_up_counter

`default_nettype wire

/* test/port_b_owner.sv */
// Far-side owner of port B
`timescale 1ns/1ps
`default_nettype none
module port_b_owner (input wire logic i_clock, i_own, i_oe,
  input wire logic [3:0] i_data, i_dev, output logic [3:0] o_wire);
  logic [3:0] junk = 4'h5;
  always @(posedge i_clock) junk <= ~junk;
  // Owner lets go in run modes; released lines wander
  assign o_wire = i_oe ? i_dev : i_own ? i_data : junk;
endmodule : port_b_owner
`default_nettype wire

/* test/dual_port_up_counter_props.sv */
// Port checks for the counter
`timescale 1ns/1ps
`default_nettype none
module dual_port_up_counter_props (input wire logic i_clock, i_reset_n, i_counter_clear,
  i_mode_select_low, i_mode_select_high, i_carry_input, i_output_enable_n,
  o_port_b_lines_oe, o_count_oe,
  input wire logic [3:0] i_port_a_inputs, i_port_b_lines, o_port_b_lines, o_count);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  wire logic h = i_mode_select_high, l = i_mode_select_low, c = i_counter_clear;
  wire logic [3:0] q = o_count;
  property p_clr; c |=> q == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_lda; !c && !h && !l |=> q == $past(i_port_a_inputs); endproperty
  a_lda: assert property (p_lda) else $error("load A");
  property p_ldb; !c && !h && l |=> q == $past(i_port_b_lines); endproperty
  a_ldb: assert property (p_ldb) else $error("load B");
  property p_inc; !c && h && i_carry_input |=> q == $past(q) + 4'h1; endproperty
  a_inc: assert property (p_inc) else $error("count");
  property p_hld; !c && h && !i_carry_input |=> $stable(q); endproperty
  a_hld: assert property (p_hld) else $error("hold");
  property p_coe; 1'b1 |=> o_count_oe != $past(i_output_enable_n); endproperty
  a_coe: assert property (p_coe) else $error("bus enable");
  property p_boe; 1'b1 |=> o_port_b_lines_oe == $past(h); endproperty
  a_boe: assert property (p_boe) else $error("B enable");
  property p_bd; o_port_b_lines_oe |->
    o_port_b_lines == ($past(l) ? {q[0], q[1], q[2], q[3]} : q); endproperty
  a_bd: assert property (p_bd) else $error("B data");
  property p_bz; !o_port_b_lines_oe |-> o_port_b_lines == 4'h0; endproperty
  a_bz: assert property (p_bz) else $error("B idle data");
endmodule : dual_port_up_counter_props
bind dual_port_up_counter dual_port_up_counter_props chk (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_counter_clear(i_counter_clear),
  .i_mode_select_low(i_mode_select_low), .i_mode_select_high(i_mode_select_high),
  .i_carry_input(i_carry_input), .i_output_enable_n(i_output_enable_n),
  .o_port_b_lines_oe(o_port_b_lines_oe), .o_count_oe(o_count_oe),
  .i_port_a_inputs(i_port_a_inputs), .i_port_b_lines(i_port_b_lines),
  .o_port_b_lines(o_port_b_lines), .o_count(o_count));
`default_nettype wire

/* test/tb_dual_port_loadable_up_counter.sv */
// Bench for the counter
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_loadable_up_counter;
  logic i_clock = 0, i_reset_n = 0, i_counter_clear = 0, i_mode_select_low = 0;
  logic i_mode_select_high = 0, i_carry_input = 0, i_output_enable_n = 1, own = 1;
  logic o_count_oe, o_port_b_lines_oe;
  logic [3:0] i_port_a_inputs = 4'h0, d = 4'h0, m = 4'h0, o_port_b_lines, o_count;
  wire logic [3:0] i_port_b_lines;
  wire logic [9:0] seen = {o_count_oe, o_port_b_lines_oe, o_port_b_lines, o_count};
  logic [9:0] q[$];
  int err_count = 0, cmp_count = 0;
  dual_port_up_counter DUT (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_counter_clear(i_counter_clear), .i_mode_select_low(i_mode_select_low),
    .i_mode_select_high(i_mode_select_high), .i_carry_input(i_carry_input),
    .i_output_enable_n(i_output_enable_n), .i_port_a_inputs(i_port_a_inputs),
    .i_port_b_lines(i_port_b_lines), .o_port_b_lines(o_port_b_lines),
    .o_port_b_lines_oe(o_port_b_lines_oe), .o_count(o_count), .o_count_oe(o_count_oe));
  port_b_owner far (.i_clock, .i_own(own), .i_data(d), .i_oe(o_port_b_lines_oe),
    .i_dev(o_port_b_lines), .o_wire(i_port_b_lines));
  initial forever #2 i_clock = ~i_clock;
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [9:0] e);
    cmp_count++;
    if (seen !== e) begin
      err_count++;
      $display("[FAIL] outputs expected %h seen %h", e, seen);
    end
  endtask : cmp
  always @(negedge i_clock) if (q.size() > 0) cmp(q.pop_front());
  initial begin
    logic [12:0] v;
    void'($urandom(79));
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (300) begin
      v = 13'($urandom);
      v[12] = &{v[12], v[5], v[0]};
      // No load from port B while the counter still drives it
      if (v[11:10] == 2'b01 && !own) v[10] = 1'b0;
      {i_counter_clear, i_mode_select_high, i_mode_select_low, i_carry_input,
        i_output_enable_n, i_port_a_inputs, d} <= v;
      own <= !v[11];
      if (v[12]) m = 4'h0;
      else if (!v[11]) m = v[10] ? v[3:0] : v[7:4];
      else if (v[9]) m = m + 4'h1;
      @(posedge i_clock);
      q.push_back({!v[8], v[11], v[11] ? (v[10] ? {m[0], m[1], m[2], m[3]} : m) : 4'h0, m});
    end
    @(posedge i_clock);
    final_report();
  end
  initial begin
    #5000;
    err_count++;
    final_report();
  end
endmodule : tb_dual_port_loadable_up_counter
`default_nettype wire
